// file: rtl/rfss_pkg.sv
/*
  constants, types and helpers for the rail fault supervisor and sequencer.
  assumes a 250 MHz mclk and linear-format (5-bit exponent, 11-bit mantissa) settings.
*/
package rfss_pkg;
  localparam int NR = 5;
  localparam logic [2:0] PG_C = 3'h2;
  localparam logic [2:0] PG_D = 3'h3;
  localparam logic [2:0] PG_L = 3'h4;
  localparam logic [2:0] PG_G = 3'h7;
  localparam int CLK_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;
  localparam int VIN_DIV = 14;
  localparam int VIN_RPT_SH = 4;
  localparam int VIN_FIX_SH = 7;
  localparam int TEMP_FIX_SH = 14;
  localparam int VO_RPT_SH = 2;
  localparam logic [4:0] VIN_EXP = 5'h1b;
  localparam logic [4:0] TEMP_EXP = 5'h1e;
  localparam logic [4:0] VO_EXP = 5'h1a;
  localparam logic signed [7:0] MARG_MAX = 8'sh0f;
  localparam logic [4:0] C_OP = 5'h00;
  localparam logic [4:0] C_RVIN = 5'h01;
  localparam logic [4:0] C_RTEMP = 5'h02;
  localparam logic [4:0] C_VON = 5'h03;
  localparam logic [4:0] C_VOFF = 5'h04;
  localparam logic [4:0] C_VUVW = 5'h05;
  localparam logic [4:0] C_VOVF = 5'h06;
  localparam logic [4:0] C_VRSP = 5'h07;
  localparam logic [4:0] C_OTF = 5'h08;
  localparam logic [4:0] C_OTW = 5'h09;
  localparam logic [4:0] C_OTRSP = 5'h0a;
  localparam logic [4:0] C_TOND = 5'h0b;
  localparam logic [4:0] C_TONR = 5'h0c;
  localparam logic [4:0] C_TOFFD = 5'h0d;
  localparam logic [4:0] C_TOFFF = 5'h0e;
  localparam logic [4:0] C_STAT = 5'h0f;
  localparam logic [4:0] C_RIOUT = 5'h10;
  localparam logic [4:0] C_RIIN = 5'h11;
  localparam logic [4:0] C_IOCF = 5'h12;
  localparam logic [4:0] C_IOCW = 5'h13;
  localparam logic [4:0] C_ICAL = 5'h14;
  localparam logic [4:0] C_VOOVF = 5'h15;
  localparam logic [4:0] C_VOUVF = 5'h16;
  localparam logic [4:0] C_VOOVW = 5'h17;
  localparam logic [4:0] C_VOUVW = 5'h18;
  localparam logic [4:0] C_MARG = 5'h19;
  localparam logic [4:0] C_VORSP = 5'h1a;
  localparam logic [4:0] C_GCFG = 5'h00;
  localparam logic [15:0] OP_RST = 16'h0080;
  localparam logic [15:0] VON_RST = 16'hf001;
  localparam logic [15:0] VOFF_RST = 16'hf000;
  localparam logic [15:0] VUVW_RST = 16'he000;
  localparam logic [15:0] VOVF_RST = 16'he200;
  localparam logic [15:0] OTF_RST = 16'h007d;
  localparam logic [15:0] OTW_RST = 16'h0073;
  localparam logic [15:0] TDLY_RST = 16'hf800;
  localparam logic [15:0] TRAMP_RST = 16'hf004;
  localparam logic [15:0] RSP_RST = 16'h0001;
  localparam logic [1:0] RSP_LATCH = 2'h1;
  localparam logic [1:0] RSP_AUTO = 2'h2;
  localparam int OP_ON = 7;
  localparam int G_ALL = 0;
  localparam int G_SLP = 1;
  localparam int G_MRG = 2;
  localparam int G_TRK = 3;
  localparam logic [15:0] G_RST = 16'h4000;

  typedef enum logic [2:0] {SEQ_OFF, SEQ_TON, SEQ_RISE, SEQ_ON, SEQ_TOFF, SEQ_FALL} rfss_seq_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } rfss_bus_t;

  typedef struct packed {
    logic [9:0]  vin;
    logic [11:0] iout;
    logic [11:0] iin;
  } rfss_sense_t;

  typedef struct packed {
    logic lreg_uvw;
    logic lreg_ovw;
    logic lreg_uvf;
    logic lreg_ovf;
    logic on;
    logic latched;
    logic uvlo;
    logic ot_warn;
    logic ot_fault;
    logic vin_uvw;
    logic vin_ovf;
  } rfss_stat_t;

  // linear code to signed fixed point with 16 fraction bits
  function automatic logic signed [47:0] lin_fix(input logic [15:0] x);
    logic signed [47:0] m;
    logic signed [5:0]  e;
    m = {{37{x[10]}}, x[10:0]} <<< 16;
    e = {x[15], x[15:11]};
    lin_fix = e[5] ? (m >>> (6'h0 - e)) : (m <<< e[4:0]);
  endfunction

  // linear milliseconds to clock cycles, saturating; negative reads as zero
  function automatic logic [31:0] dly_cyc(input logic [15:0] x, input logic [31:0] cpm);
    logic [63:0] p;
    logic [5:0]  e;
    e = {x[15], x[15:11]};
    p = x[10] ? 64'h0 : 64'(x[9:0]) * 64'(cpm);
    p = e[5] ? (p >> (6'h0 - e)) : (p << e[4:0]);
    dly_cyc = (|p[63:32]) ? 32'hffffffff : p[31:0];
  endfunction

  function automatic logic [15:0] lin_half(input logic [15:0] x);
    lin_half = (x[15:11] == 5'h10) ? {x[15:11], x[10], x[10:1]} : {x[15:11] - 5'h01, x[10:0]};
  endfunction

  function automatic logic [15:0] cfg_def(input logic [4:0] c);
    case (c)
      C_OP:                        cfg_def = OP_RST;
      C_VON:                       cfg_def = VON_RST;
      C_VOFF:                      cfg_def = VOFF_RST;
      C_VUVW:                      cfg_def = VUVW_RST;
      C_VOVF:                      cfg_def = VOVF_RST;
      C_OTF:                       cfg_def = OTF_RST;
      C_OTW:                       cfg_def = OTW_RST;
      C_TOND, C_TOFFD:             cfg_def = TDLY_RST;
      C_TONR, C_TOFFF:             cfg_def = TRAMP_RST;
      C_VRSP, C_OTRSP, C_VORSP:    cfg_def = RSP_RST;
      default:                     cfg_def = 16'h0000;
    endcase
  endfunction
endpackage

// file: rtl/rfss_top.sv
/*
  rail fault supervisor and sequencer: input and temperature supervision,
  fault responses, five-rail sequencing, sleep reset, c/d merge, linear regulator.
  assumes inputs synchronous to mclk and a one-cycle strobe register port.
*/
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
// What this block does
// - report input voltage scaled by fixed divider
// - undervoltage lockout with on/off hysteresis thresholds
// - input undervoltage warning and overvoltage fault compare
// - input overvoltage response: ignore or latch off
// - clear latch by enable, supply, operation
// - rails a,b share one sensor; rest other
// - temperature reported in quarter degree steps
// - over temperature fault and warning compare
// - over temperature: ignore, latch, auto restart
// - clear temperature latch by enable, supply, operation
// - programmable delays and ramps; regulator delay only
// - all-rail bit spreads latch and auto-off shutdowns
// - without all-rail bit other rails continue, except merged d, which stops with c
// - sleep pin forces reset and nonvolatile reload
// - merged c drives d stage, 180 degrees
// - refuse every command to d when merged
// - merged c currents report c plus d
// - merged c current limits halve into both
// - regulator tracking mode uses half input
// - regulator margin command within fifteen percent
// - regulator output limits read-only, computed internally
// - regulator faults by digital compare only
// - limits 125, 75, 112.5, 87.5 percent
module rfss_top #(
  parameter int          CYC_MS = rfss_pkg::CYC_PER_MS,
  parameter logic [15:0] GLB_NV = rfss_pkg::G_RST
) (
  input  logic                  mclk,
  input  logic                  rst_b,
  input  rfss_pkg::rfss_bus_t   bus,
  output logic [15:0]           rdata,
  output logic                  cmd_nack,
  input  logic [4:0]            en_pin,
  input  logic                  sleep_n,
  input  rfss_pkg::rfss_sense_t sense [rfss_pkg::NR],
  input  logic signed [10:0]    temp_ab,
  input  logic signed [10:0]    temp_cdl,
  input  logic [11:0]           lreg_vin,
  input  logic [11:0]           lreg_vout,
  output logic [4:0]            rail_en,
  output logic [4:0]            rail_ramp,
  output logic                  d_stage_from_c,
  output logic                  c_phase_180,
  output logic                  lreg_track,
  output logic [12:0]           lreg_ref,
  output logic                  nv_reload
);
  import rfss_pkg::*;

  logic [2:0]         page;
  logic [4:0]         cmd;
  logic               merged;
  logic               nack_hit;
  logic               sleep_act;
  logic               vol_rst;
  logic               wr_hit;
  logic               sleep_q;
  logic [15:0]        glb_reg;
  logic [15:0]        cfg_reg [NR][32];
  logic [15:0]        rd_val;
  logic [15:0]        rdata_reg;
  logic               nack_reg;
  rfss_seq_t          st_reg [NR];
  logic [31:0]        cnt_reg [NR];
  logic [NR-1:0]      lat_reg;
  logic [NR-1:0]      vok_reg;
  logic [4:0]         en_reg;
  logic [4:0]         ramp_reg;
  logic               dfc_reg;
  logic               c180_reg;
  logic               trk_reg;
  logic [12:0]        ref_reg;
  logic               nvr_reg;
  logic [2:0]         src [NR];
  logic [13:0]        vsc [NR];
  logic signed [10:0] tsel [NR];
  logic signed [47:0] vfx [NR];
  logic signed [47:0] tfx [NR];
  logic [31:0]        t_on [NR];
  logic [31:0]        t_rise [NR];
  logic [31:0]        t_off [NR];
  logic [31:0]        t_fall [NR];
  logic [15:0]        iout_rd [NR];
  logic [15:0]        iin_rd [NR];
  rfss_stat_t         stat [NR];
  logic [NR-1:0]      ovf, uvw, otf, otw, trip, aoff, down, kill, want, clr, op_on;
  logic               glob_kill;
  logic [11:0]        tgt;
  logic [12:0]        l_ovf, l_uvf, l_ovw, l_uvw;
  logic               l_of, l_uf, l_ow, l_uw;
  logic signed [7:0]  mraw, mg;
  logic signed [21:0] mprod;

  assign page = bus.addr[7:5];
  assign cmd = bus.addr[4:0];
  assign merged = glb_reg[G_MRG];
  assign nack_hit = merged && page == PG_D;
  // sleep pulls the volatile state into reset; the nonvolatile settings survive
  assign sleep_act = glb_reg[G_SLP] & ~sleep_n;
  assign vol_rst = ~rst_b | sleep_act;

  function automatic logic wr_ok(input logic [2:0] p, input logic [4:0] c);
    case (c)
      C_OP, C_VON, C_VOFF, C_VUVW, C_VOVF, C_VRSP,
      C_OTF, C_OTW, C_OTRSP, C_TOND:                   wr_ok = p <= PG_L;
      C_TONR, C_TOFFD, C_TOFFF, C_IOCF, C_IOCW, C_ICAL: wr_ok = p < PG_L;
      C_MARG, C_VORSP:                                 wr_ok = p == PG_L;
      default:                                         wr_ok = 1'b0;
    endcase
  endfunction

  assign wr_hit = bus.wr & ~sleep_act & ~nack_hit & wr_ok(page, cmd);

  // linear regulator target, margin and digital limits
  always_comb begin
    tgt = glb_reg[G_TRK] ? (lreg_vin >> 1) : {2'h0, glb_reg[15:8], 2'h0};
    l_ovf = 13'(tgt) + 13'(tgt >> 2);
    l_uvf = 13'(tgt - (tgt >> 2));
    l_ovw = 13'(tgt) + 13'(tgt >> 3);
    l_uvw = 13'(tgt - (tgt >> 3));
    l_of = 13'(lreg_vout) > l_ovf;
    l_uf = 13'(lreg_vout) < l_uvf;
    l_ow = 13'(lreg_vout) > l_ovw;
    l_uw = 13'(lreg_vout) < l_uvw;
    mraw = cfg_reg[PG_L][C_MARG][7:0];
    mg = (mraw > MARG_MAX) ? MARG_MAX : ((mraw < -MARG_MAX) ? -MARG_MAX : mraw);
    mprod = 22'($signed({1'b0, tgt}) * mg) / 22'sd100;
  end

  // per-rail supervision
  always_comb begin
    glob_kill = 1'b0;
    for (int i = 0; i < NR; i++) begin
      src[i] = (merged && i == 3) ? PG_C : 3'(i);
      vsc[i] = 14'(sense[i].vin * VIN_DIV);
      vfx[i] = $signed({34'h0, vsc[i]}) <<< VIN_FIX_SH;
      tsel[i] = (i < 2) ? temp_ab : temp_cdl;
      tfx[i] = $signed({{37{tsel[i][10]}}, tsel[i]}) <<< TEMP_FIX_SH;
      ovf[i] = vfx[i] > lin_fix(cfg_reg[src[i]][C_VOVF]);
      uvw[i] = vfx[i] < lin_fix(cfg_reg[src[i]][C_VUVW]);
      otf[i] = tfx[i] > lin_fix(cfg_reg[src[i]][C_OTF]);
      otw[i] = tfx[i] > lin_fix(cfg_reg[src[i]][C_OTW]);
      op_on[i] = cfg_reg[src[i]][C_OP][OP_ON];
      clr[i] = ~en_pin[src[i]] | ~op_on[i];
      // warnings take no part in these terms
      trip[i] = (ovf[i] && cfg_reg[src[i]][C_VRSP][1:0] == RSP_LATCH)
              | (otf[i] && cfg_reg[src[i]][C_OTRSP][1:0] == RSP_LATCH)
              | (i == 4 && (l_of | l_uf) && cfg_reg[PG_L][C_VORSP][1:0] == RSP_LATCH);
      aoff[i] = otf[i] && cfg_reg[src[i]][C_OTRSP][1:0] == RSP_AUTO;
      down[i] = lat_reg[i] | trip[i] | aoff[i];
      glob_kill = glob_kill | (down[i] & glb_reg[G_ALL]);
      t_on[i] = dly_cyc(cfg_reg[src[i]][C_TOND], 32'(CYC_MS));
      t_rise[i] = (i == 4) ? 32'h0 : dly_cyc(cfg_reg[src[i]][C_TONR], 32'(CYC_MS));
      t_off[i] = (i == 4) ? 32'h0 : dly_cyc(cfg_reg[src[i]][C_TOFFD], 32'(CYC_MS));
      t_fall[i] = (i == 4) ? 32'h0 : dly_cyc(cfg_reg[src[i]][C_TOFFF], 32'(CYC_MS));
      iout_rd[i] = 16'(sense[i].iout) + cfg_reg[i][C_ICAL];
      iin_rd[i] = 16'(sense[i].iin);
      stat[i] = '{lreg_uvw: i == 4 && l_uw, lreg_ovw: i == 4 && l_ow,
                  lreg_uvf: i == 4 && l_uf, lreg_ovf: i == 4 && l_of,
                  on: st_reg[i] == SEQ_ON, latched: lat_reg[i], uvlo: ~vok_reg[i],
                  ot_warn: otw[i], ot_fault: otf[i], vin_uvw: uvw[i], vin_ovf: ovf[i]};
    end
    if (merged) begin
      iout_rd[2] = 16'(sense[2].iout) + 16'(sense[3].iout) + cfg_reg[PG_C][C_ICAL];
      iin_rd[2] = 16'(sense[2].iin) + 16'(sense[3].iin);
    end
    for (int i = 0; i < NR; i++) begin
      kill[i] = down[i] | glob_kill;
      want[i] = en_pin[src[i]] & op_on[i] & vok_reg[i] & ~kill[i];
    end
    if (merged) begin
      kill[3] = kill[3] | kill[2];
      want[3] = want[2];
    end
  end

  // read mux; unmapped and refused addresses read as zero
  always_comb begin
    rd_val = 16'h0000;
    if (page == PG_G && cmd == C_GCFG) begin
      rd_val = glb_reg;
    end else if (page <= PG_L && !nack_hit) begin
      case (cmd)
        C_RVIN:  rd_val = {VIN_EXP, 11'(vsc[page] >> VIN_RPT_SH)};
        C_RTEMP: rd_val = {TEMP_EXP, tsel[page]};
        C_STAT:  rd_val = {5'h00, stat[page]};
        C_RIOUT: rd_val = iout_rd[page];
        C_RIIN:  rd_val = iin_rd[page];
        C_VOOVF: rd_val = (page == PG_L) ? {VO_EXP, 11'(l_ovf >> VO_RPT_SH)} : 16'h0;
        C_VOUVF: rd_val = (page == PG_L) ? {VO_EXP, 11'(l_uvf >> VO_RPT_SH)} : 16'h0;
        C_VOOVW: rd_val = (page == PG_L) ? {VO_EXP, 11'(l_ovw >> VO_RPT_SH)} : 16'h0;
        C_VOUVW: rd_val = (page == PG_L) ? {VO_EXP, 11'(l_uvw >> VO_RPT_SH)} : 16'h0;
        default: rd_val = wr_ok(page, cmd) ? cfg_reg[page][cmd] : 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      glb_reg <= GLB_NV;
    end else if (bus.wr && !sleep_act && page == PG_G && cmd == C_GCFG) begin
      glb_reg <= bus.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (vol_rst) begin
      for (int p = 0; p < NR; p++) begin
        for (int c = 0; c < 32; c++) begin
          cfg_reg[p][c] <= cfg_def(5'(c));
        end
      end
    end else if (wr_hit) begin
      if (merged && page == PG_C && (cmd == C_IOCF || cmd == C_IOCW)) begin
        cfg_reg[PG_C][cmd] <= lin_half(bus.wdata);
        cfg_reg[PG_D][cmd] <= lin_half(bus.wdata);
      end else begin
        cfg_reg[page][cmd] <= bus.wdata;
      end
    end
  end

  // communication is dead while asleep
  always_ff @(posedge mclk) begin
    if (vol_rst) begin
      rdata_reg <= 16'h0000;
      nack_reg <= 1'b0;
    end else begin
      rdata_reg <= bus.rd ? rd_val : 16'h0000;
      nack_reg <= (bus.rd | bus.wr) & nack_hit;
    end
  end

  // set wins over clear; supply cycling is the reset itself
  always_ff @(posedge mclk) begin
    if (vol_rst) begin
      lat_reg <= '0;
    end else begin
      lat_reg <= trip | (lat_reg & ~clr);
    end
  end

  always_ff @(posedge mclk) begin
    if (vol_rst) begin
      vok_reg <= '0;
    end else begin
      for (int i = 0; i < NR; i++) begin
        if (vfx[i] >= lin_fix(cfg_reg[src[i]][C_VON])) begin
          vok_reg[i] <= 1'b1;
        end else if (vfx[i] < lin_fix(cfg_reg[src[i]][C_VOFF])) begin
          vok_reg[i] <= 1'b0;
        end
      end
    end
  end

  // a fault drops the rail at once; a normal off runs the off delay and fall
  always_ff @(posedge mclk) begin
    if (vol_rst) begin
      for (int i = 0; i < NR; i++) begin
        st_reg[i] <= SEQ_OFF;
        cnt_reg[i] <= 32'h0;
      end
    end else begin
      for (int i = 0; i < NR; i++) begin
        case (st_reg[i])
          SEQ_OFF: begin
            if (want[i]) begin
              st_reg[i] <= SEQ_TON;
              cnt_reg[i] <= t_on[i];
            end
          end
          SEQ_TON: begin
            if (kill[i] || !want[i]) begin
              st_reg[i] <= SEQ_OFF;
            end else if (cnt_reg[i] == 32'h0) begin
              st_reg[i] <= SEQ_RISE;
              cnt_reg[i] <= t_rise[i];
            end else begin
              cnt_reg[i] <= cnt_reg[i] - 32'h1;
            end
          end
          SEQ_RISE, SEQ_ON: begin
            if (kill[i]) begin
              st_reg[i] <= SEQ_OFF;
            end else if (!want[i]) begin
              st_reg[i] <= SEQ_TOFF;
              cnt_reg[i] <= t_off[i];
            end else if (st_reg[i] == SEQ_ON) begin
              st_reg[i] <= SEQ_ON;
            end else if (cnt_reg[i] == 32'h0) begin
              st_reg[i] <= SEQ_ON;
            end else begin
              cnt_reg[i] <= cnt_reg[i] - 32'h1;
            end
          end
          SEQ_TOFF: begin
            if (kill[i]) begin
              st_reg[i] <= SEQ_OFF;
            end else if (want[i]) begin
              st_reg[i] <= SEQ_ON;
            end else if (cnt_reg[i] == 32'h0) begin
              st_reg[i] <= SEQ_FALL;
              cnt_reg[i] <= t_fall[i];
            end else begin
              cnt_reg[i] <= cnt_reg[i] - 32'h1;
            end
          end
          SEQ_FALL: begin
            if (kill[i] || cnt_reg[i] == 32'h0) begin
              st_reg[i] <= SEQ_OFF;
            end else begin
              cnt_reg[i] <= cnt_reg[i] - 32'h1;
            end
          end
          default: st_reg[i] <= SEQ_OFF;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (vol_rst) begin
      en_reg <= '0;
      ramp_reg <= '0;
    end else begin
      for (int i = 0; i < NR; i++) begin
        en_reg[i] <= st_reg[i] != SEQ_OFF && st_reg[i] != SEQ_TON;
        ramp_reg[i] <= st_reg[i] == SEQ_RISE || st_reg[i] == SEQ_FALL;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      dfc_reg <= 1'b0;
      c180_reg <= 1'b0;
      trk_reg <= 1'b0;
      ref_reg <= 13'h0;
    end else begin
      dfc_reg <= merged;
      c180_reg <= merged;
      trk_reg <= glb_reg[G_TRK];
      ref_reg <= 13'($signed({1'b0, tgt}) + mprod);
    end
  end

  // reload request marks the end of a sleep reset
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sleep_q <= 1'b0;
      nvr_reg <= 1'b0;
    end else begin
      sleep_q <= sleep_act;
      nvr_reg <= sleep_q & ~sleep_act;
    end
  end

  assign rdata = rdata_reg;
  assign cmd_nack = nack_reg;
  assign rail_en = en_reg;
  assign rail_ramp = ramp_reg;
  assign d_stage_from_c = dfc_reg;
  assign c_phase_180 = c180_reg;
  assign lreg_track = trk_reg;
  assign lreg_ref = ref_reg;
  assign nv_reload = nvr_reg;
endmodule

// file: bench/rfss_top_asserts.sv
/*
  port-level checks of the rail fault supervisor and sequencer.
  assumes mclk as the only clock and the one-cycle strobe register port.
*/
`timescale 1ns/10ps
module rfss_top_asserts (
  input wire logic            mclk,
  input wire logic            rst_b,
  input rfss_pkg::rfss_bus_t   bus,
  input wire logic [15:0]     rdata,
  input wire logic            cmd_nack,
  input wire logic            sleep_n,
  input rfss_pkg::rfss_sense_t sense [rfss_pkg::NR],
  input wire logic signed [10:0] temp_ab,
  input wire logic signed [10:0] temp_cdl,
  input wire logic [4:0]      rail_en,
  input wire logic [4:0]      rail_ramp,
  input wire logic            d_stage_from_c,
  input wire logic            c_phase_180,
  input wire logic            nv_reload
);
  import rfss_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 16'h0000)
    else $error("read data seen outside the answer cycle");
  a_vin_read: assert property ($past(bus.rd) && $past(bus.addr) == 8'h01 |->
    rdata == {5'h1b, 11'((14'($past(sense[0].vin)) * 14'd14) >> 4)})
    else $error("input voltage read does not match divider scaling");
  a_temp_ab: assert property ($past(bus.rd) && $past(bus.addr) == 8'h02 |->
    rdata == {5'h1e, $past(temp_ab)})
    else $error("rail a temperature not from the first sensor");
  a_temp_lreg: assert property ($past(bus.rd) && $past(bus.addr) == 8'h82 |->
    rdata == {5'h1e, $past(temp_cdl)})
    else $error("regulator temperature not from the second sensor");
  a_nack_cause: assert property (cmd_nack |-> $past(bus.rd || bus.wr)
    && $past(bus.addr[7:5]) == 3'h3 && d_stage_from_c)
    else $error("refusal without a merged rail d access");
  a_merge_pair: assert property (d_stage_from_c == c_phase_180)
    else $error("merged stage and phase select disagree");
  a_ramp_in_en: assert property ((rail_ramp & ~rail_en) == 5'h00)
    else $error("ramp flagged on a disabled rail");
  a_ramp_on_rise: assert property (((rail_en & ~$past(rail_en)) & ~rail_ramp) == 5'h00)
    else $error("rail enabled without a ramp phase");
  a_reload_pulse: assert property (nv_reload |=> !nv_reload)
    else $error("reload longer than one cycle");
  a_reload_wake: assert property (nv_reload |-> $past(sleep_n) &&
    !($past(sleep_n, 2) && $past(sleep_n, 3) && $past(sleep_n, 4)))
    else $error("reload not tied to the end of a sleep");
  c_nack: cover property (cmd_nack);
  c_reload: cover property (nv_reload);
  c_lreg_up: cover property ($rose(rail_en[4]));
endmodule
bind rfss_top rfss_top_asserts u_chk (.mclk(mclk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
  .cmd_nack(cmd_nack), .sleep_n(sleep_n), .sense(sense), .temp_ab(temp_ab),
  .temp_cdl(temp_cdl), .rail_en(rail_en), .rail_ramp(rail_ramp),
  .d_stage_from_c(d_stage_from_c), .c_phase_180(c_phase_180), .nv_reload(nv_reload));

// file: bench/rfss_host.sv
/*
  host side of the register port: one-cycle write and read strobes.
  assumes the bench calls its tasks and a slave that never stalls.
*/
`timescale 1ns/10ps
module rfss_host (
  output rfss_pkg::rfss_bus_t bus,
  input  wire logic          mclk,
  input  wire logic [15:0]   rdata,
  input  wire logic          cmd_nack
);
  import rfss_pkg::*;
  initial bus = '0;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask
  // answer stands only in the cycle after the strobe, so it is taken there
  task automatic rd(input logic [7:0] a, output logic [15:0] q, output logic n);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    #1;
    q = rdata;
    n = cmd_nack;
  endtask
endmodule

// file: bench/rfss_top_tb.sv
/*
  self-checking bench of the rail fault supervisor and sequencer.
  assumes the host model on the register port and a shortened ms count.
*/
`timescale 1ns/10ps
module rfss_top_tb;
  import rfss_pkg::*;
  logic               mclk = 1'b0;
  logic               rst_b = 1'b0;
  logic [4:0]         en_pin = 5'h00;
  logic               sleep_n = 1'b1;
  logic signed [10:0] temp_ab = 11'sd100;
  logic signed [10:0] temp_cdl = 11'sd100;
  logic [11:0]        lreg_vin = 12'h000;
  // sits at the default regulator target so no output limit trips at start
  logic [11:0]        lreg_vout = 12'h100;
  rfss_sense_t        sense [NR];
  rfss_bus_t          bus;
  logic [15:0]        rdata, q;
  logic [4:0]         rail_en, rail_ramp;
  logic [12:0]        lreg_ref;
  logic               cmd_nack, nk, d_stage_from_c, c_phase_180, lreg_track, nv_reload;
  int                 n_mismatch = 0, n_compared = 0, seed = 93640, cyc = 0, i, k;
  logic [23:0]        tbl [10] = '{24'h03f001, 24'h04f000, 24'h05e000, 24'h06e200,
    24'h08007d, 24'h090073, 24'h0bf800, 24'h2cf004, 24'h8bf800, 24'he04000};
  rfss_host host (.bus(bus), .mclk(mclk), .rdata(rdata), .cmd_nack(cmd_nack));
  rfss_top #(.CYC_MS(10)) DUT (.mclk(mclk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .cmd_nack(cmd_nack), .en_pin(en_pin), .sleep_n(sleep_n), .sense(sense),
    .temp_ab(temp_ab), .temp_cdl(temp_cdl), .lreg_vin(lreg_vin), .lreg_vout(lreg_vout),
    .rail_en(rail_en), .rail_ramp(rail_ramp), .d_stage_from_c(d_stage_from_c),
    .c_phase_180(c_phase_180), .lreg_track(lreg_track), .lreg_ref(lreg_ref),
    .nv_reload(nv_reload));
  initial forever #2 mclk = ~mclk;
  function automatic logic [15:0] fvin(input logic [9:0] v);
    fvin = {5'h1b, 11'((14'(v) * 14'd14) >> 4)};
  endfunction
  // percentage of a value, truncated; wide enough for 125 percent of any target
  function automatic logic [15:0] fpct(input logic [15:0] t, input logic [15:0] p);
    fpct = 16'(32'(t) * 32'(p) / 32'd100);
  endfunction
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // bounded wait for the rail pattern, then one compare
  task automatic wt(input logic [4:0] e);
    for (int j = 0; j < 300 && rail_en !== e; j++) begin
      @(posedge mclk);
      #1;
    end
    chk({11'h0, rail_en}, {11'h0, e});
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    for (i = 0; i < NR; i++) sense[i] = '{vin: 10'd439, iout: 12'h000, iin: 12'h000};
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    for (i = 0; i < 10; i++) begin
      host.rd(tbl[i][23:16], q, nk);
      chk(q, tbl[i][15:0]);
    end
    $display("test defaults done");
    for (i = 0; i < 8; i++) begin
      k = $random(seed);
      @(posedge mclk);
      sense[i % 3].vin <= 10'd100 + 10'(k[8:0]);
      temp_ab <= 11'(k[16:9]);
      temp_cdl <= 11'(k[24:17]);
      host.rd({3'(i % 3), 5'h01}, q, nk);
      chk(q, fvin(sense[i % 3].vin));
      host.rd(8'h02, q, nk);
      chk(q, {5'h1e, temp_ab});
      host.rd(8'h42, q, nk);
      chk(q, {5'h1e, temp_cdl});
      host.rd(8'h82, q, nk);
      chk(q, {5'h1e, temp_cdl});
    end
    $display("test telemetry done");
    @(posedge mclk);
    en_pin <= 5'h1f;
    wt(5'h1f);
    temp_cdl <= 11'sd480;
    repeat (12) @(posedge mclk);
    host.rd(8'h4f, q, nk);
    chk(q & 16'h0048, 16'h0048);
    temp_cdl <= 11'sd504;
    wt(5'h03);
    temp_cdl <= 11'sd100;
    repeat (30) @(posedge mclk);
    #1;
    chk({11'h0, rail_en}, 16'h0003);
    en_pin <= 5'h03;
    repeat (3) @(posedge mclk);
    en_pin <= 5'h1f;
    wt(5'h1f);
    $display("test temperature latch done");
    host.wr(8'h0a, 16'h0002);
    host.wr(8'h2a, 16'h0002);
    temp_ab <= 11'sd504;
    wt(5'h1c);
    temp_ab <= 11'sd100;
    wt(5'h1f);
    $display("test auto restart done");
    host.wr(8'h26, 16'he100);
    sense[1].vin <= 10'd731;
    wt(5'h1d);
    sense[1].vin <= 10'd439;
    host.wr(8'h20, 16'h0000);
    host.wr(8'h20, 16'h0080);
    wt(5'h1f);
    $display("test input overvoltage done");
    host.wr(8'he0, 16'h4001);
    temp_ab <= 11'sd504;
    wt(5'h00);
    temp_ab <= 11'sd100;
    wt(5'h1f);
    host.wr(8'he0, 16'h4000);
    $display("test all rail done");
    k = $random(seed);
    sense[2].iout <= 12'(k[10:0]);
    sense[3].iout <= 12'(k[21:11]);
    host.wr(8'he0, 16'h4004);
    host.rd(8'h6f, q, nk);
    chk(q, 16'h0000);
    chk({15'h0, nk}, 16'h0001);
    chk({15'h0, d_stage_from_c}, 16'h0001);
    host.rd(8'h50, q, nk);
    chk(q, 16'(sense[2].iout) + 16'(sense[3].iout));
    host.wr(8'h52, 16'h0a40);
    host.rd(8'h52, q, nk);
    chk(q, 16'h0240);
    host.wr(8'he0, 16'h4002);
    $display("test merge done");
    sleep_n <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    chk({11'h0, rail_en}, 16'h0000);
    sleep_n <= 1'b1;
    for (i = 0; i < 10 && nv_reload !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk({15'h0, nv_reload}, 16'h0001);
    host.rd(8'h26, q, nk);
    chk(q, 16'he200);
    $display("test sleep done");
    k = $random(seed);
    lreg_vin <= 12'(k);
    host.wr(8'he0, 16'h4008);
    repeat (4) @(posedge mclk);
    #1;
    chk({15'h0, lreg_track}, 16'h0001);
    chk({3'h0, lreg_ref}, {5'h00, lreg_vin[11:1]});
    host.wr(8'h99, 16'h0014);
    host.rd(8'h99, q, nk);
    chk(q, 16'h0014);
    chk({3'h0, lreg_ref}, 16'(lreg_vin[11:1]) + fpct(16'(lreg_vin[11:1]), 16'd15));
    host.rd(8'h95, q, nk);
    chk(q, {5'h1a, 11'(fpct(16'(lreg_vin[11:1]), 16'd125) >> 2)});
    $display("test regulator done");
    conclude();
  end
endmodule
